// >>> cme_top.sv
/*
 * Comparator control register behind an AXI4-Lite slave, input source
 * selects, result pin drive and edge-selected interrupt request.
 * Assumes a master with at most one write and one read outstanding.
 */
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module cme_top
   import cme_pkg::*;
#(
   parameter int ADDR_W = 4
)(
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   input  wire logic              cmp_raw_i,
   output logic                   cmp_enable_o,
   output logic                   positive_input_select_o,
   output logic [1:0]             negative_input_select_o,
   output logic                   result_pin_o,
   output logic                   result_pin_oe_o,
   output logic                   irq_o
);
   //----------------------------------------------------------------
   // Control register
   //----------------------------------------------------------------
   logic [31:0]       ctrl_q;
   logic              aw_got_q;
   logic              w_got_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic [31:0]       bmask;
   logic              do_write;
   logic              wr_hit;
   logic [31:0]       rd_word;

   cme_evt_if evt ();

   assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid_o;
   assign wr_hit   = (awaddr_q[ADDR_W-1:2] == CME_CTRL_OFFSET[ADDR_W-1:2]);
   assign bmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   // Only writable fields change; each field keeps its value otherwise
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ctrl_q <= CME_CTRL_RESET;
      end else if (ce_i && do_write && wr_hit) begin
         ctrl_q <= (ctrl_q & ~(bmask & CME_CTRL_WMASK))
                 | (wdata_q & bmask & CME_CTRL_WMASK);
      end
   end

   // Live result is spliced in at read time so writes cannot touch it
   always_comb begin
      rd_word = ctrl_q & CME_CTRL_WMASK;
      rd_word[CME_LIVE_BIT] = evt.result;
   end

   //----------------------------------------------------------------
   // AXI4-Lite write path: address and data taken in either order
   //----------------------------------------------------------------
   assign s_axi_awready_o = ~aw_got_q;
   assign s_axi_wready_o  = ~w_got_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         aw_got_q <= 1'b0;
         awaddr_q <= '0;
      end else if (ce_i) begin
         if (s_axi_awvalid_i && !aw_got_q) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
         end else if (do_write) begin
            aw_got_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         w_got_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (ce_i) begin
         if (s_axi_wvalid_i && !w_got_q) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
         end else if (do_write) begin
            w_got_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= CME_RESP_OKAY;
      end else if (ce_i) begin
         if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? CME_RESP_OKAY : CME_RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------------
   // AXI4-Lite read path
   //----------------------------------------------------------------
   // Ready is held low while a read answer waits, so one read at a time
   assign s_axi_arready_o = ~s_axi_rvalid_o;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= '0;
         s_axi_rresp_o  <= CME_RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
            s_axi_rvalid_o <= 1'b1;
            if (s_axi_araddr_i[ADDR_W-1:2] == CME_CTRL_OFFSET[ADDR_W-1:2]) begin
               s_axi_rdata_o <= rd_word;
               s_axi_rresp_o <= CME_RESP_OKAY;
            end else begin
               s_axi_rdata_o <= '0;
               s_axi_rresp_o <= CME_RESP_SLVERR;
            end
         end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   //----------------------------------------------------------------
   // Result conditioning and events
   //----------------------------------------------------------------
   assign evt.raw    = cmp_raw_i;
   assign evt.enable = ctrl_q[CME_ON_BIT];
   assign evt.invert = ctrl_q[CME_INVERT_BIT];

   cme_event_det u_det (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .evt    (evt)
   );

   // Changing the invert bit while enabled flips the conditioned level and may itself fire
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         case (ctrl_q[CME_EDGE_HI:CME_EDGE_LO])
            CME_EDGE_NONE: irq_o <= 1'b0;
            CME_EDGE_RISE: irq_o <= evt.rise;
            CME_EDGE_FALL: irq_o <= evt.fall;
            CME_EDGE_BOTH: irq_o <= evt.rise | evt.fall;
            default:       irq_o <= 1'b0;
         endcase
      end else begin
         irq_o <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cmp_enable_o            <= 1'b0;
         positive_input_select_o <= 1'b0;
         negative_input_select_o <= CME_CTRL_RESET[CME_NEG_HI:CME_NEG_LO];
         result_pin_o            <= 1'b0;
         result_pin_oe_o         <= 1'b0;
      end else if (ce_i) begin
         cmp_enable_o            <= ctrl_q[CME_ON_BIT];
         positive_input_select_o <= ctrl_q[CME_POS_BIT];
         negative_input_select_o <= ctrl_q[CME_NEG_HI:CME_NEG_LO];
         result_pin_o            <= ctrl_q[CME_DRIVE_BIT] & evt.result;
         result_pin_oe_o         <= ctrl_q[CME_DRIVE_BIT];
      end
   end
endmodule
`default_nettype wire

// >>> cme_pkg.sv
/*
 * Constants for the comparator control and event logic: register offset,
 * field positions, reset value and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus and one analog comparator.
 */
package cme_pkg;
   localparam logic [3:0]  CME_CTRL_OFFSET  = 4'h0;
   localparam int          CME_ON_BIT       = 15;
   localparam int          CME_DRIVE_BIT    = 14;
   localparam int          CME_INVERT_BIT   = 13;
   localparam int          CME_LIVE_BIT     = 8;
   localparam int          CME_EDGE_HI      = 7;
   localparam int          CME_EDGE_LO      = 6;
   localparam int          CME_POS_BIT      = 4;
   localparam int          CME_NEG_HI       = 1;
   localparam int          CME_NEG_LO       = 0;
   localparam logic [31:0] CME_CTRL_RESET   = 32'h0000_00C3;
   localparam logic [31:0] CME_CTRL_WMASK   = 32'h0000_E0D3;
   localparam logic [1:0]  CME_EDGE_NONE    = 2'h0;
   localparam logic [1:0]  CME_EDGE_RISE    = 2'h1;
   localparam logic [1:0]  CME_EDGE_FALL    = 2'h2;
   localparam logic [1:0]  CME_EDGE_BOTH    = 2'h3;
   localparam logic [1:0]  CME_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  CME_RESP_SLVERR  = 2'h2;
endpackage

// >>> cme_evt_if.sv
/*
 * Signals between the control block and its result synchroniser.
 * Assumes both ends run on the same peripheral clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface cme_evt_if;
   logic raw;
   logic enable;
   logic invert;
   logic result;
   logic rise;
   logic fall;
   modport det (input raw, input enable, input invert, output result, output rise, output fall);
   modport ctl (output raw, output enable, output invert, input result, input rise, input fall);
endinterface
`default_nettype wire

// >>> cme_event_det.sv
/*
 * Synchroniser, polarity stage and edge detector for the comparator result.
 * Assumes the raw result is asynchronous to mclk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module cme_event_det
   import cme_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   cme_evt_if.det    evt
);
   logic sync1_q;
   logic sync2_q;
   logic res_q;
   logic prev_q;

   // Two-stage synchroniser; only sync2_q reads sync1_q
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else if (ce_i) begin
         sync1_q <= evt.raw;
         sync2_q <= sync1_q;
      end
   end

   // A powered-down comparator reads as low rather than floating
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         res_q  <= 1'b0;
         prev_q <= 1'b0;
      end else if (ce_i) begin
         res_q  <= evt.enable & (sync2_q ^ evt.invert);
         prev_q <= res_q;
      end
   end

   assign evt.result = res_q;
   assign evt.rise   = res_q & ~prev_q;
   assign evt.fall   = ~res_q & prev_q;
endmodule
`default_nettype wire

// >>> cme_top_chk.sv
/* Concurrent checks on the ports of cme_top.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ns
`default_nettype none
module cme_chk (
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        cmp_raw_i,
   input  wire logic        cmp_enable_o,
   input  wire logic        result_pin_o,
   input  wire logic        result_pin_oe_o,
   input  wire logic        irq_o,
   input  wire logic        s_axi_bvalid_o,
   input  wire logic        s_axi_arready_o,
   input  wire logic        s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   input  wire logic [31:0] s_axi_rdata_o
);
   logic       raw_q;
   logic [2:0] quiet_q;
   logic [2:0] off_q;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Quiet counters
   // ----------------------------------------
   // Count only while running, since a stopped clock enable freezes the synchroniser
   always_ff @(posedge mclk_i) begin
      raw_q <= cmp_raw_i;
      if (rst_i || cmp_raw_i != raw_q || s_axi_bvalid_o) quiet_q <= 3'h0;
      else if (ce_i && quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i || cmp_enable_o) off_q <= 3'h0;
      else if (ce_i && off_q != 3'h7) off_q <= off_q + 3'h1;
   end
   pin_off_a: assert property (!result_pin_oe_o |-> !result_pin_o)
      else $error("result pin high while not driven");
   quiet_irq_a: assert property (quiet_q >= 3'h6 |-> !irq_o)
      else $error("interrupt without a result transition");
   off_quiet_a: assert property (off_q >= 3'h4 |-> !result_pin_o && !irq_o)
      else $error("disabled comparator still active");
   ce_stop_a: assert property (!ce_i |=> !irq_o)
      else $error("interrupt while clock enable low");
   rsv_zero_a: assert property (s_axi_rvalid_o |-> (s_axi_rdata_o & 32'hFFFF_1E2C) == 32'h0)
      else $error("unimplemented bits read nonzero");
   ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read address accepted during read answer");
   rd_end_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read answer held after handshake");
   cfg_write_a: assert property ($changed({cmp_enable_o, result_pin_oe_o})
      |-> s_axi_bvalid_o || $past(s_axi_bvalid_o))
      else $error("control output changed without a write");
endmodule
bind cme_top cme_chk chk_u (.mclk_i, .rst_i, .ce_i, .cmp_raw_i, .cmp_enable_o,
   .result_pin_o, .result_pin_oe_o, .irq_o, .s_axi_bvalid_o, .s_axi_arready_o,
   .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o);
`default_nettype wire

// >>> tb_cme_top.sv
/* Self-checking bench for cme_top: register bus, selects, pin drive, events.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
`default_nettype none
module tb_cme_top;
   import cme_pkg::*;
   logic        mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, raw = 1'b0;
   logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
   logic [3:0]  awa = 4'h0, ara = 4'h0;
   logic [31:0] wd = 32'h0, rd, rdata;
   logic [1:0]  rsp, bresp, rresp, neg;
   logic        awr, wrd, bv, arr, rv, en, pos, pin, oe, irq;
   int          err_count = 0, samples_checked = 0;
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
   cme_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(aw_v), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v), .s_axi_wready_o(wrd),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(b_r),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(r_r), .cmp_raw_i(raw), .cmp_enable_o(en),
      .positive_input_select_o(pos), .negative_input_select_o(neg),
      .result_pin_o(pin), .result_pin_oe_o(oe), .irq_o(irq));
   always #20 mclk_i = ~mclk_i;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Handshakes are judged at the falling edge, where ready has settled
   task automatic xfer(input bit wr, input logic [3:0] a, input logic [31:0] d);
      bit done, ah, wh, qh, bh, rh;
      done = 1'b0;
      if (wr) begin
         awa <= a; wd <= d; aw_v <= 1'b1; w_v <= 1'b1; b_r <= 1'b1;
      end else begin
         ara <= a; ar_v <= 1'b1; r_r <= 1'b1;
      end
      for (int n = 0; n < 20 && !done; n++) begin
         @(negedge mclk_i);
         ah = aw_v & awr; wh = w_v & wrd; qh = ar_v & arr; bh = b_r & bv; rh = r_r & rv;
         if (bh) rsp = bresp;
         if (rh) begin
            rsp = rresp; rd = rdata;
         end
         @(posedge mclk_i);
         if (ah) aw_v <= 1'b0;
         if (wh) w_v <= 1'b0;
         if (qh) ar_v <= 1'b0;
         if (bh || rh) begin
            done = 1'b1; b_r <= 1'b0; r_r <= 1'b0;
         end
      end
      if (!done) begin
         err_count++;
         wrap_up();
      end else begin
         // One idle edge: the next call never re-raises a strobe in the step that lowered it,
         // and outputs launched at the answer edge are settled when the caller looks
         @(posedge mclk_i);
      end
   endtask
   // Four-state tally, so an unknown request level cannot pass as zero
   task automatic count(output logic [3:0] c);
      c = 4'h0;
      repeat (8) begin
         @(negedge mclk_i);
         c = c + {3'h0, irq};
      end
      @(posedge mclk_i);
   endtask
   task automatic t_regs();
      xfer(1'b0, 4'h0, 32'h0);
      `CHK(rd, CME_CTRL_RESET)
      `CHK({en, oe, pos, neg}, 5'h03)
      xfer(1'b1, 4'h0, 32'hFFFF_DFFF);
      xfer(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h0000_C0D3)
      `CHK(pin, 1'b0)
      xfer(1'b1, 4'h0, 32'h0000_A000);
      tick(6);
      `CHK({pin, oe}, 2'b00)
      xfer(1'b1, 4'h4, 32'h0000_FFFF);
      `CHK(rsp, CME_RESP_SLVERR)
      xfer(1'b0, 4'hC, 32'h0);
      `CHK({rsp, rd}, {CME_RESP_SLVERR, 32'h0})
      xfer(1'b0, 4'h0, 32'h0);
      `CHK(rd, 32'h0000_A100)
   endtask
   task automatic t_sel();
      for (int k = 0; k < 8; k++) begin
         xfer(1'b1, 4'h0, {27'h0, k[2], 2'b00, k[1:0]});
         `CHK({pos, neg}, k[2:0])
      end
   endtask
   // Every edge code, each without and with inversion
   task automatic t_edge();
      logic [3:0] nr, nf;
      for (int k = 0; k < 8; k++) begin
         xfer(1'b1, 4'h0, {16'h0, 2'b11, k[2], 5'h0, k[1:0], 6'h0});
         tick(8);
         raw <= 1'b1;
         count(nr);
         xfer(1'b0, 4'h0, 32'h0);
         `CHK({rd[8], pin}, {2{~k[2]}})
         raw <= 1'b0;
         count(nf);
         `CHK(nr, k[2] ? k[1] : k[0])
         `CHK(nf, k[2] ? k[0] : k[1])
      end
   endtask
   task automatic t_off();
      logic [3:0] n;
      xfer(1'b1, 4'h0, 32'h0000_60C0);
      tick(6);
      raw <= 1'b1;
      count(n);
      `CHK({n[3:0], pin}, 5'h00)
      `CHK({en, oe}, 2'b01)
      xfer(1'b1, 4'h0, 32'h0000_80C0);
      tick(6);
      `CHK({en, oe}, 2'b10)
      ce_i <= 1'b0;
      raw <= 1'b0;
      count(n);
      `CHK(n, 0)
      ce_i <= 1'b1;
      count(n);
      `CHK(n, 1)
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      t_regs();
      t_sel();
      t_edge();
      t_off();
      wrap_up();
   end
endmodule
`default_nettype wire
